// ==== design/sqs_top.sv ====
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module sqs_top (
    input  wire logic                 sys_clk,            // core clock
    input  wire logic                 rst,                // async reset, active high
    input  wire logic                 frame_valid,        // one frame per pulse
    input  wire sqs_pkg::sqs_frame_t  frame,              // classified frame
    input  wire logic [11:0]          avs_address,        // word address
    input  wire logic                 avs_read,           // read request
    input  wire logic                 avs_write,          // write request
    input  wire logic [31:0]          avs_writedata,      // write data
    output logic [31:0]               avs_readdata,       // read data
    output logic                      avs_waitrequest     // stall
);
    localparam int SVC_TYPES_L = sqs_pkg::SVC_TYPES;

    logic [13:0] addr;
    logic        ack;
    logic        next_ack;
    logic        wr_acc;
    logic        rd_first;

    logic        vlan_as_service_index_en;
    logic        policer_colour_select;
    logic [7:0]  drop_prec_colour_map;
    logic [5:0]  svc_count_bytes_sel;
    logic [1:0]  q_count_bytes_sel;
    logic [5:0]  svc_mask [SVC_TYPES_L];
    logic [1:0]  q_mask [2];
    logic [7:0]  hi_stage;
    logic [7:0]  shadow;

    logic        next_vlan_en;
    logic        next_pol_sel;
    logic [7:0]  next_map;
    logic [5:0]  next_svc_bsel;
    logic [1:0]  next_q_bsel;
    logic [5:0]  next_svc_mask [SVC_TYPES_L];
    logic [1:0]  next_q_mask [2];
    logic [7:0]  next_hi_stage;
    logic [7:0]  next_shadow;
    logic [31:0] next_readdata;
    logic        svc_clear;

    // counter window decode
    logic                    svc_sel;
    logic                    q_sel;
    logic [sqs_pkg::SVC_IW-1:0] a_svc_entry;
    logic [2:0]              a_svc_type;
    logic [sqs_pkg::Q_IW-1:0] a_q_entry;
    logic                    a_q_type;
    logic                    a_hi;
    logic [39:0]             svc_rd [SVC_TYPES_L];
    logic [39:0]             q_rd [2];

    // frame classification
    logic [1:0]              colour;
    logic [5:0]              svc_ev;
    logic [1:0]              q_ev;
    logic [sqs_pkg::SVC_IW-1:0] svc_idx;
    logic [sqs_pkg::Q_IW-1:0] q_idx;
    logic [8:0]              base_plus_cos;

    assign addr        = {avs_address, 2'b00};
    assign next_ack    = (avs_read | avs_write) & ~ack;
    // one wait cycle: request seen, then answered
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign wr_acc      = avs_write & ack;
    assign rd_first    = avs_read & ~ack;

    assign svc_sel     = (addr[13:12] == sqs_pkg::OFF_SVC_CNT[13:12]) && (a_svc_type < 3'h6);
    assign q_sel       = (addr[13:10] == sqs_pkg::OFF_Q_CNT[13:10]);
    assign a_svc_entry = addr[11:6];
    assign a_svc_type  = addr[5:3];
    assign a_q_entry   = addr[9:4];
    assign a_q_type    = addr[3];
    assign a_hi        = addr[2];

    assign base_plus_cos = {3'h0, frame.service_base_address}
                         + {6'h0, frame.service_cos_offset};
    // index wraps into the implemented entries
    assign svc_idx = vlan_as_service_index_en ? frame.vid[5:0]
                                              : base_plus_cos[5:0];
    assign q_idx   = {frame.igr_port, frame.iprio};

    always_comb begin
        if (policer_colour_select) begin
            colour = frame.policer_colour;
        end else begin
            colour = drop_prec_colour_map[{frame.drop_precedence, 1'b0} +: 2];
        end
    end

    // green, yellow, red, unicast, multicast, flood
    assign svc_ev = {frame.cast == sqs_pkg::CAST_FLOOD,
                     frame.cast == sqs_pkg::CAST_MC,
                     frame.cast == sqs_pkg::CAST_UC,
                     colour == sqs_pkg::COL_RED,
                     colour == sqs_pkg::COL_YELLOW,
                     colour == sqs_pkg::COL_GREEN};
    assign q_ev   = {frame.qpol_dropped,
                     frame.qpol_applied & ~frame.qpol_dropped};

    assign svc_clear = wr_acc && (addr == sqs_pkg::OFF_SVC_RESET)
                       && avs_writedata[0];

    genvar k;
    generate
        for (k = 0; k < SVC_TYPES_L; k++) begin : g_svc
            logic [39:0] cnt [sqs_pkg::SVC_N];
            logic        hit;
            logic        sw_lo;
            logic [39:0] sum;
            logic [39:0] wval;

            assign hit   = frame_valid && ((svc_mask[k] & svc_ev) != 6'h0);
            assign sum   = cnt[svc_idx] + (svc_count_bytes_sel[k]
                           ? {26'h0, frame.byte_len} : 40'h1);
            assign sw_lo = wr_acc && svc_sel && !a_hi && (a_svc_type == 3'(k));
            // wide types take the high part from the staged write, narrow types write it as zero
            assign wval  = (k < sqs_pkg::SVC_WIDE) ? {hi_stage, avs_writedata}
                                                   : {8'h0, avs_writedata};
            assign svc_rd[k] = cnt[a_svc_entry];

            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    for (int i = 0; i < sqs_pkg::SVC_N; i++) begin
                        cnt[i] <= 40'h0;
                    end
                end else if (svc_clear) begin
                    for (int i = 0; i < sqs_pkg::SVC_N; i++) begin
                        cnt[i] <= 40'h0;
                    end
                end else begin
                    if (hit) begin
                        // narrow types keep only 32 bits, so they wrap there
                        cnt[svc_idx] <= (k < sqs_pkg::SVC_WIDE) ? sum
                                        : {8'h0, sum[31:0]};
                    end
                    if (sw_lo) begin
                        cnt[a_svc_entry] <= wval;
                    end
                end
            end
        end

        for (k = 0; k < 2; k++) begin : g_q
            logic [39:0] cnt [sqs_pkg::Q_N];
            logic        hit;
            logic        sw_lo;

            assign hit   = frame_valid && ((q_mask[k] & q_ev) != 2'h0);
            assign sw_lo = wr_acc && q_sel && !a_hi && (a_q_type == 1'(k));
            assign q_rd[k] = cnt[a_q_entry];

            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    for (int i = 0; i < sqs_pkg::Q_N; i++) begin
                        cnt[i] <= 40'h0;
                    end
                end else begin
                    if (hit) begin
                        cnt[q_idx] <= cnt[q_idx] + (q_count_bytes_sel[k]
                                      ? {26'h0, frame.byte_len} : 40'h1);
                    end
                    if (sw_lo) begin
                        cnt[a_q_entry] <= {hi_stage, avs_writedata};
                    end
                end
            end
        end
    endgenerate

    always_comb begin
        next_vlan_en  = vlan_as_service_index_en;
        next_pol_sel  = policer_colour_select;
        next_map      = drop_prec_colour_map;
        next_svc_bsel = svc_count_bytes_sel;
        next_q_bsel   = q_count_bytes_sel;
        next_svc_mask = svc_mask;
        next_q_mask   = q_mask;
        next_hi_stage = hi_stage;
        if (wr_acc) begin
            if (addr == sqs_pkg::OFF_CTRL) begin
                next_vlan_en = avs_writedata[0];
                next_pol_sel = avs_writedata[1];
            end else if (addr == sqs_pkg::OFF_COLOUR_MAP) begin
                next_map = avs_writedata[7:0];
            end else if (addr == sqs_pkg::OFF_BYTES_SEL) begin
                next_svc_bsel = avs_writedata[5:0];
                next_q_bsel   = avs_writedata[9:8];
            end else if (addr[13:5] == sqs_pkg::OFF_SVC_MASK[13:5] && addr[4:2] < 3'h6) begin
                next_svc_mask[addr[4:2]] = avs_writedata[5:0];
            end else if (addr[13:3] == sqs_pkg::OFF_Q_MASK[13:3]) begin
                next_q_mask[addr[2]] = avs_writedata[1:0];
            end else if ((svc_sel && a_svc_type < 3'h3 || q_sel) && a_hi) begin
                next_hi_stage = avs_writedata[7:0];
            end
        end
    end

    always_comb begin
        next_readdata = 32'h0;
        next_shadow   = shadow;
        if (addr == sqs_pkg::OFF_CTRL) begin
            next_readdata = {30'h0, policer_colour_select, vlan_as_service_index_en};
        end else if (addr == sqs_pkg::OFF_COLOUR_MAP) begin
            next_readdata = {24'h0, drop_prec_colour_map};
        end else if (addr == sqs_pkg::OFF_BYTES_SEL) begin
            next_readdata = {22'h0, q_count_bytes_sel, 2'h0, svc_count_bytes_sel};
        end else if (addr[13:5] == sqs_pkg::OFF_SVC_MASK[13:5] && addr[4:2] < 3'h6) begin
            next_readdata = {26'h0, svc_mask[addr[4:2]]};
        end else if (addr[13:3] == sqs_pkg::OFF_Q_MASK[13:3]) begin
            next_readdata = {30'h0, q_mask[addr[2]]};
        end else if (svc_sel) begin
            if (!a_hi) begin
                next_readdata = svc_rd[a_svc_type][31:0];
                if (rd_first && a_svc_type < 3'h3) begin
                    next_shadow = svc_rd[a_svc_type][39:32];
                end
            end else if (a_svc_type < 3'h3) begin
                next_readdata = {24'h0, shadow};
            end
        end else if (q_sel) begin
            if (!a_hi) begin
                next_readdata = q_rd[a_q_type][31:0];
                if (rd_first) begin
                    next_shadow = q_rd[a_q_type][39:32];
                end
            end else begin
                next_readdata = {24'h0, shadow};
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ack                      <= 1'b0;
            avs_readdata             <= 32'h0;
            shadow                   <= 8'h0;
            hi_stage                 <= 8'h0;
            vlan_as_service_index_en <= sqs_pkg::CTRL_RST[0];
            policer_colour_select    <= sqs_pkg::CTRL_RST[1];
            drop_prec_colour_map     <= sqs_pkg::COLOUR_MAP_RST;
            svc_count_bytes_sel      <= 6'h0;
            q_count_bytes_sel        <= 2'h0;
            for (int i = 0; i < SVC_TYPES_L; i++) begin
                svc_mask[i] <= 6'h0;
            end
            q_mask[0]                <= 2'h0;
            q_mask[1]                <= 2'h0;
        end else begin
            ack                      <= next_ack;
            if (rd_first) begin
                avs_readdata <= next_readdata;
                shadow       <= next_shadow;
            end
            hi_stage                 <= next_hi_stage;
            vlan_as_service_index_en <= next_vlan_en;
            policer_colour_select    <= next_pol_sel;
            drop_prec_colour_map     <= next_map;
            svc_count_bytes_sel      <= next_svc_bsel;
            q_count_bytes_sel        <= next_q_bsel;
            svc_mask                 <= next_svc_mask;
            q_mask                   <= next_q_mask;
        end
    end
endmodule

// ==== common/sqs_pkg.sv ====
package sqs_pkg;
    localparam int SVC_IW   = 6;
    localparam int SVC_N    = 1 << SVC_IW;
    localparam int Q_IW     = 6;
    localparam int Q_N      = 1 << Q_IW;
    localparam int SVC_TYPES = 6;
    localparam int SVC_WIDE  = 3;
    localparam int Q_TYPES   = 2;
    localparam int ADDR_W    = 14;

    localparam logic [13:0] OFF_CTRL       = 14'h0000;
    localparam logic [13:0] OFF_COLOUR_MAP = 14'h0004;
    localparam logic [13:0] OFF_SVC_RESET  = 14'h0008;
    localparam logic [13:0] OFF_BYTES_SEL  = 14'h000c;
    localparam logic [13:0] OFF_SVC_MASK   = 14'h0020;
    localparam logic [13:0] OFF_Q_MASK     = 14'h0040;
    localparam logic [13:0] OFF_SVC_CNT    = 14'h1000;
    localparam logic [13:0] OFF_Q_CNT      = 14'h2000;

    localparam logic [7:0] COLOUR_MAP_RST = 8'ha4;
    localparam logic [1:0] CTRL_RST       = 2'h0;

    localparam logic [1:0] COL_GREEN  = 2'h0;
    localparam logic [1:0] COL_YELLOW = 2'h1;
    localparam logic [1:0] COL_RED    = 2'h2;

    localparam logic [1:0] CAST_UC    = 2'h0;
    localparam logic [1:0] CAST_MC    = 2'h1;
    localparam logic [1:0] CAST_FLOOD = 2'h2;

    typedef struct packed {
        logic [5:0]  service_base_address;
        logic [2:0]  service_cos_offset;
        logic [11:0] vid;
        logic [2:0]  igr_port;
        logic [2:0]  iprio;
        logic [1:0]  drop_precedence;
        logic [1:0]  policer_colour;
        logic [1:0]  cast;
        logic        qpol_applied;
        logic        qpol_dropped;
        logic [13:0] byte_len;
    } sqs_frame_t;
endpackage

// ==== sim/sqs_properties.sv ====
`timescale 1ns/1ps
module sqs_properties (
    input wire logic                sys_clk,         // clock
    input wire logic                rst,             // reset
    input wire logic                frame_valid,     // frame strobe
    input wire sqs_pkg::sqs_frame_t frame,           // frame
    input wire logic [11:0]         avs_address,     // word address
    input wire logic                avs_read,        // read
    input wire logic                avs_write,       // write
    input wire logic [31:0]         avs_writedata,   // write data
    input wire logic [31:0]         avs_readdata,    // read data
    input wire logic                avs_waitrequest  // stall
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [13:0] ba;
    logic [1:0]  last_ctrl;
    logic [1:0]  next_last_ctrl;
    assign ba = {avs_address, 2'h0};
    always_comb begin
        next_last_ctrl = last_ctrl;
        if (avs_write && !avs_waitrequest && ba == sqs_pkg::OFF_CTRL) begin
            next_last_ctrl = avs_writedata[1:0];
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            last_ctrl <= 2'h0;
        end else begin
            last_ctrl <= next_last_ctrl;
        end
    end
    sequence rd_done;
        avs_read && !avs_waitrequest;
    endsequence
    sequence one_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    one_wait_a: assert property ($rose(avs_read || avs_write) |-> one_wait)
        else $error("access did not finish after one wait cycle");
    ctrl_readback_a: assert property (rd_done ##0 ba == sqs_pkg::OFF_CTRL
        |-> avs_readdata == {30'h0, last_ctrl}) else $error("control readback wrong");
    reset_reads_zero_a: assert property (rd_done ##0 ba == sqs_pkg::OFF_SVC_RESET
        |-> avs_readdata == 32'h0) else $error("clear control read not zero");
    svc_mask_width_a: assert property (rd_done ##0 (ba >= 14'h0020 && ba < 14'h0038)
        |-> avs_readdata[31:6] == 26'h0) else $error("service mask too wide");
    q_mask_width_a: assert property (rd_done ##0 ba[13:3] == 11'h008
        |-> avs_readdata[31:2] == 30'h0) else $error("queue mask too wide");
    narrow_high_a: assert property (rd_done ##0 (ba[13:12] == 2'h1 && ba[5:3] >= 3'h3
        && ba[2]) |-> avs_readdata == 32'h0) else $error("narrow counter high word not zero");
    wide_high_a: assert property (rd_done ##0 (ba[13:12] != 2'h0 && ba[2])
        |-> avs_readdata[31:8] == 24'h0) else $error("high word wider than 8 bits");
    bytesel_width_a: assert property (rd_done ##0 ba == sqs_pkg::OFF_BYTES_SEL
        |-> (avs_readdata & 32'hfffffcc0) == 32'h0) else $error("byte select too wide");
    cmap_width_a: assert property (rd_done ##0 ba == sqs_pkg::OFF_COLOUR_MAP
        |-> avs_readdata[31:8] == 24'h0) else $error("colour map too wide");
endmodule
bind sqs_top sqs_properties u_props (.sys_clk(sys_clk), .rst(rst), .frame_valid(frame_valid),
    .frame(frame), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

// ==== sim/sqs_frame_src.sv ====
`timescale 1ns/1ps
module sqs_frame_src (
    input  wire logic           sys_clk,      // clock
    input  wire logic           rst,          // reset
    input  wire logic           stall,        // hold frames back
    output logic                frame_valid,  // frame strobe
    output sqs_pkg::sqs_frame_t frame         // frame fields
);
    sqs_pkg::sqs_frame_t pending [$];
    // idle fields toggle so a stale frame never looks valid by accident
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            frame_valid <= 1'b0;
            frame <= '0;
        end else if (!stall && pending.size() > 0) begin
            frame_valid <= 1'b1;
            frame <= pending.pop_front();
        end else begin
            frame_valid <= 1'b0;
            frame <= ~frame;
        end
    end
endmodule

// ==== sim/test_sqs_top.sv ====
`timescale 1ns/1ps
module test_sqs_top;
    logic                sys_clk, rst, stall, frame_valid, avs_read, avs_write, avs_waitrequest;
    sqs_pkg::sqs_frame_t frame, f;
    logic [11:0]         avs_address;
    logic [31:0]         avs_writedata, avs_readdata, rd;
    logic [39:0]         v;
    logic [63:0]         rnd;
    integer              num_errors = 0, total_checks = 0, seed = 76, ctrl, cmap, bsel, n;
    integer              mask [8];
    longint              svc [64][6], qc [64][2];
    sqs_top dut (.sys_clk(sys_clk), .rst(rst), .frame_valid(frame_valid), .frame(frame),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    sqs_frame_src src (.sys_clk(sys_clk), .rst(rst), .stall(stall),
        .frame_valid(frame_valid), .frame(frame));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) stall <= ($random(seed) % 4) == 0;
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [13:0] ba, input logic [31:0] wd);
        int k;
        avs_address <= ba[13:2];
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= wd;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        if (avs_waitrequest !== 1'b0) begin
            num_errors++;
            end_sim();
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd40(input logic [13:0] ba);
        bus(1'b0, ba, 32'h0);
        v[31:0] = rd;
        bus(1'b0, ba + 14'h4, 32'h0);
        v[39:32] = rd[7:0];
    endtask
    task automatic wr40(input logic [13:0] ba, input logic [39:0] val);
        bus(1'b1, ba + 14'h4, {24'h0, val[39:32]});
        bus(1'b1, ba, val[31:0]);
    endtask
    task automatic send;
        logic [1:0] col;
        logic [5:0] ev, idx;
        logic [1:0] qe;
        col = ctrl[1] ? f.policer_colour : 2'(cmap >> (2 * f.drop_precedence));
        ev = (col < 3 ? 6'h1 << col : 6'h0) | (f.cast < 3 ? 6'h8 << f.cast : 6'h0);
        idx = ctrl[0] ? f.vid[5:0] : 6'(f.service_base_address + f.service_cos_offset);
        qe = {f.qpol_dropped, f.qpol_applied & !f.qpol_dropped};
        for (int t = 0; t < 6; t++) begin
            if ((mask[t] & ev) != 0) begin
                svc[idx][t] = (svc[idx][t] + (bsel[t] ? f.byte_len : 1))
                    % (64'h1 << (t < 3 ? 40 : 32));
            end
        end
        for (int t = 0; t < 2; t++) begin
            if ((mask[6+t] & qe) != 0) begin
                qc[{f.igr_port, f.iprio}][t] = (qc[{f.igr_port, f.iprio}][t]
                    + (bsel[8+t] ? f.byte_len : 1)) % (64'h1 << 40);
            end
        end
        src.pending.push_back(f);
    endtask
    initial begin
        rst = 1'b1;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        foreach (qc[q, t]) qc[q][t] = 0;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        bus(1'b0, sqs_pkg::OFF_CTRL, 32'h0);
        chk(rd, 0);
        bus(1'b0, sqs_pkg::OFF_COLOUR_MAP, 32'h0);
        chk(rd, sqs_pkg::COLOUR_MAP_RST);
        bus(1'b0, 14'h3ffc, 32'h0);
        chk(rd, 0);
        for (int r = 0; r < 4; r++) begin
            ctrl = r;
            cmap = $random(seed) & 8'hff;
            bsel = $random(seed) & 32'h33f;
            bus(1'b1, sqs_pkg::OFF_CTRL, ctrl);
            bus(1'b1, sqs_pkg::OFF_COLOUR_MAP, cmap);
            bus(1'b1, sqs_pkg::OFF_BYTES_SEL, bsel);
            bus(1'b0, sqs_pkg::OFF_BYTES_SEL, 32'h0);
            chk(rd, bsel);
            for (int k = 0; k < 8; k++) begin
                mask[k] = $random(seed) & (k < 6 ? 8'h3f : 8'h3);
                n = k < 6 ? sqs_pkg::OFF_SVC_MASK + 4 * k : sqs_pkg::OFF_Q_MASK + 4 * (k - 6);
                bus(1'b1, 14'(n), mask[k]);
                bus(1'b0, 14'(n), 32'h0);
                chk(rd, mask[k]);
            end
            bus(1'b1, sqs_pkg::OFF_SVC_RESET, 32'h1);
            foreach (svc[e, t]) svc[e][t] = 0;
            wr40(sqs_pkg::OFF_SVC_CNT, 40'hff_ffff_fff0);
            wr40(sqs_pkg::OFF_SVC_CNT + 14'h18, 40'hff_ffff_fff0);
            wr40(sqs_pkg::OFF_Q_CNT + 14'h8, 40'hff_ffff_ff00);
            svc[0][0] = 40'hff_ffff_fff0;
            svc[0][3] = 32'hffff_fff0;
            qc[0][1] = 40'hff_ffff_ff00;
            for (int i = 0; i < 300; i++) begin
                rnd = {$random(seed), $random(seed)};
                f = rnd[48:0];
                f.service_base_address &= 6'h3;
                f.service_cos_offset &= 3'h3;
                f.vid &= 12'hfc7;
                send();
            end
            n = 0;
            while (src.pending.size() > 0 && n < 5000) begin
                @(posedge sys_clk);
                n++;
            end
            if (n >= 5000) begin
                num_errors++;
                end_sim();
            end
            repeat (2) @(posedge sys_clk);
            foreach (svc[e, t]) begin
                if (e < 8) begin
                    rd40(14'(sqs_pkg::OFF_SVC_CNT + e * 64 + t * 8));
                    chk(v, 40'(svc[e][t]));
                end
            end
            foreach (qc[q, t]) begin
                rd40(14'(sqs_pkg::OFF_Q_CNT + q * 16 + t * 8));
                chk(v, 40'(qc[q][t]));
            end
            // shadow is shared: a high read elsewhere must still show the latched snapshot
            wr40(sqs_pkg::OFF_Q_CNT, 40'h5a_0000_0000);
            qc[0][0] = 40'h5a_0000_0000;
            bus(1'b0, sqs_pkg::OFF_SVC_CNT, 32'h0);
            bus(1'b0, sqs_pkg::OFF_Q_CNT + 14'h4, 32'h0);
            chk(rd, 40'(svc[0][0] >> 32));
        end
        end_sim();
    end
endmodule
